/* File: include/gpio_port_pkg.sv */
// Package: register map, reset values and carrier structs for the port block
package gpio_port_pkg;
	localparam int port_width = 8;
	localparam logic [7:0] addr_port0_latch = 8'h80;
	localparam logic [7:0] addr_port1_latch = 8'h90;
	localparam logic [7:0] addr_port2_latch = 8'ha0;
	localparam logic [7:0] addr_port0_output_drive = 8'ha4;
	localparam logic [7:0] addr_port1_output_drive = 8'ha5;
	localparam logic [7:0] addr_port0_crossbar_skip = 8'hd4;
	localparam logic [7:0] addr_port1_crossbar_skip = 8'hd5;
	localparam logic [7:0] addr_port0_input_mode = 8'hf1;
	localparam logic [7:0] addr_port1_input_mode = 8'hf2;
	localparam logic [7:0] reset_port_latch = 8'hff;
	localparam logic [7:0] reset_port2_latch = 8'h01;
	localparam logic [7:0] reset_output_drive = 8'h00;
	localparam logic [7:0] reset_crossbar_skip = 8'h00;
	localparam logic [7:0] reset_input_mode = 8'hff;
	localparam logic [7:0] unused_read_value = 8'h00;
	localparam int port2_bit = 0;
	localparam int sync_stages = 2;

	// Register access request from the core
	typedef struct packed {
		logic [7:0] addr;
		logic write;
		logic read;
		logic rmw;
		logic bit_op;
		logic [2:0] bit_index;
		logic [7:0] wdata;
	} sfr_request_type;

	// Crossbar routing for one 8-pin port
	typedef struct packed {
		logic [7:0] claimed;
		logic [7:0] periph_out;
		logic [7:0] periph_oe;
		logic [7:0] smbus_pin;
	} route_type;
endpackage

/* File: hw/pin_sync.sv */
// Two-stage synchroniser for a bus of pin levels
`timescale 1ns/1ns
`default_nettype none
module pin_sync
	import gpio_port_pkg::*;
#(
	parameter int width = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [width-1:0] async_in,
	output logic [width-1:0] sync_out
);
	logic [width-1:0] stage1;

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			stage1 <= '0;
			sync_out <= '0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule
`default_nettype wire

/* File: hw/general_purpose_port_io.sv */
// Port latches and pin drivers for ports 0, 1 and 2, mode registers for ports 0 and 1
// Summary of operation
// R1 - Pins not claimed by crossbar or analog serve as latch-driven GPIO.
// R2 - Port latches accept whole-byte and single-bit access.
// R3 - Written latch value is held and drives pins until rewritten.
// R4 - Normal port read returns live pin level, even if crossbar-assigned.
// R5 - Read-modify-write operations read the latch, not the pins.
// R6 - Latch 0 drives low; 1 drives high, or floats if open-drain.
// R7 - Ports 0 and 1 read 0 on analog pins, pin level otherwise.
// R8 - Input-mode 0 makes pin analog: no pull-up, driver or receiver.
// R9 - Output-mode 0 open-drain, 1 push-pull; ignored for analog pins.
// R10 - SMBus data and clock pins are always open-drain.
// R11 - Skip bit 1 makes crossbar pass over the pin; 0 keeps it.
// R12 - Software sets skip bits on analog and special-function pins.
// R13 - Port 2 latch bits 7..1 read zero; only bit 0 writable.
// R14 - Port 2 pin read returns its level with no analog gating.
// R15 - Latch data appears only on pins no peripheral has claimed.
// R16 - All drivers off while crossbar enable is clear.
// R17 - Weak pull-up on open-drain pins not driving low, if enabled.
// R18 - Pin levels pass a two-stage synchroniser before being read.
`timescale 1ns/1ns
`default_nettype none
module general_purpose_port_io
	import gpio_port_pkg::*;
#(
	parameter int width = port_width
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire sfr_request_type sfr_req,
	output logic [7:0] sfr_rdata,
	output logic sfr_hit,
	input wire logic crossbar_enable_bit,
	input wire logic weak_pullup_disable,
	input wire route_type route0,
	input wire route_type route1,
	input wire logic port2_claimed,
	input wire logic port2_periph_out,
	input wire logic port2_periph_oe,
	input wire logic port2_smbus_pin,
	input wire logic port2_output_drive,
	input wire logic [width-1:0] port0_in,
	input wire logic [width-1:0] port1_in,
	input wire logic port2_in,
	output logic [width-1:0] port0_out,
	output logic [width-1:0] port0_oe,
	output logic [width-1:0] port0_pullup,
	output logic [width-1:0] port0_analog,
	output logic [width-1:0] port1_out,
	output logic [width-1:0] port1_oe,
	output logic [width-1:0] port1_pullup,
	output logic [width-1:0] port1_analog,
	output logic port2_out,
	output logic port2_oe,
	output logic port2_pullup,
	output logic [width-1:0] port0_crossbar_skip,
	output logic [width-1:0] port1_crossbar_skip
);
	logic [7:0] port0_latch;
	logic [7:0] port1_latch;
	logic [7:0] port2_latch;
	logic [7:0] port0_output_drive;
	logic [7:0] port1_output_drive;
	logic [7:0] port0_input_mode;
	logic [7:0] port1_input_mode;
	logic [7:0] skip0_reg;
	logic [7:0] skip1_reg;
	logic [width-1:0] sync0;
	logic [width-1:0] sync1;
	logic sync2;
	logic [7:0] pin_view;
	logic [7:0] latch_view;
	logic [7:0] next_value;
	logic [7:0] read_value;
	logic hit;

	pin_sync #(.width(width)) sync_p0 (
		.clk(clk), .rst_n(rst_n), .async_in(port0_in), .sync_out(sync0)
	); // R18
	pin_sync #(.width(width)) sync_p1 (
		.clk(clk), .rst_n(rst_n), .async_in(port1_in), .sync_out(sync1)
	); // R18
	pin_sync #(.width(1)) sync_p2 (
		.clk(clk), .rst_n(rst_n), .async_in(port2_in), .sync_out(sync2)
	); // R18

	// Pin levels and latch contents seen at the addressed register
	always_comb begin
		hit = 1'b1;
		pin_view = 8'h00;
		latch_view = 8'h00;
		if (sfr_req.addr == addr_port0_latch) begin
			pin_view = sync0 & port0_input_mode; // R7
			latch_view = port0_latch;
		end else if (sfr_req.addr == addr_port1_latch) begin
			pin_view = sync1 & port1_input_mode; // R7
			latch_view = port1_latch;
		end else if (sfr_req.addr == addr_port2_latch) begin
			pin_view = {7'b000_0000, sync2}; // R14 R13
			latch_view = port2_latch;
		end else if (sfr_req.addr == addr_port0_output_drive) begin
			pin_view = port0_output_drive;
			latch_view = port0_output_drive;
		end else if (sfr_req.addr == addr_port1_output_drive) begin
			pin_view = port1_output_drive;
			latch_view = port1_output_drive;
		end else if (sfr_req.addr == addr_port0_crossbar_skip) begin
			pin_view = skip0_reg;
			latch_view = skip0_reg;
		end else if (sfr_req.addr == addr_port1_crossbar_skip) begin
			pin_view = skip1_reg;
			latch_view = skip1_reg;
		end else if (sfr_req.addr == addr_port0_input_mode) begin
			pin_view = port0_input_mode;
			latch_view = port0_input_mode;
		end else if (sfr_req.addr == addr_port1_input_mode) begin
			pin_view = port1_input_mode;
			latch_view = port1_input_mode;
		end else begin
			hit = 1'b0;
			pin_view = unused_read_value;
			latch_view = unused_read_value;
		end
	end

	// Read source and merged write value
	always_comb begin
		read_value = sfr_req.rmw ? latch_view : pin_view; // R4 R5
		next_value = sfr_req.wdata;
		if (sfr_req.bit_op) begin
			// Bit writes merge into the latch, never the pins
			next_value = latch_view; // R2 R5
			next_value[sfr_req.bit_index] = sfr_req.wdata[0]; // R2
		end
	end

	// Hit flag for mapped reads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_hit <= 1'b0;
		end else begin
			sfr_hit <= sfr_req.read & hit; // R2
		end
	end

	// Read data holds until the next read
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_req.read) begin
			sfr_rdata <= hit ? read_value : unused_read_value;
		end
	end

	// Port latches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port0_latch <= reset_port_latch;
			port1_latch <= reset_port_latch;
			port2_latch <= reset_port2_latch;
		end else if (sfr_req.write) begin
			if (sfr_req.addr == addr_port0_latch) begin
				port0_latch <= next_value; // R3
			end else if (sfr_req.addr == addr_port1_latch) begin
				port1_latch <= next_value; // R3
			end else if (sfr_req.addr == addr_port2_latch) begin
				port2_latch <= {7'b000_0000, next_value[port2_bit]}; // R13
			end
		end
	end

	// Mode and skip registers
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port0_output_drive <= reset_output_drive;
			port1_output_drive <= reset_output_drive;
			skip0_reg <= reset_crossbar_skip;
			skip1_reg <= reset_crossbar_skip;
			port0_input_mode <= reset_input_mode;
			port1_input_mode <= reset_input_mode;
		end else if (sfr_req.write) begin
			if (sfr_req.addr == addr_port0_output_drive) begin
				port0_output_drive <= next_value;
			end else if (sfr_req.addr == addr_port1_output_drive) begin
				port1_output_drive <= next_value;
			end else if (sfr_req.addr == addr_port0_crossbar_skip) begin
				skip0_reg <= next_value; // R11
			end else if (sfr_req.addr == addr_port1_crossbar_skip) begin
				skip1_reg <= next_value; // R11
			end else if (sfr_req.addr == addr_port0_input_mode) begin
				port0_input_mode <= next_value; // R8
			end else if (sfr_req.addr == addr_port1_input_mode) begin
				port1_input_mode <= next_value; // R8
			end
		end
	end

	// Per-pin driver logic for ports 0 and 1
	genvar i;
	generate
		for (i = 0; i < width; i++) begin : g_pin
			logic d0, d1, oe0, oe1, pp0, pp1, low0, low1;
			// Latch drives only unclaimed pins
			assign d0 = route0.claimed[i] ? route0.periph_out[i]
				: port0_latch[i]; // R1 R15
			assign d1 = route1.claimed[i] ? route1.periph_out[i]
				: port1_latch[i]; // R1 R15
			assign oe0 = route0.claimed[i] ? route0.periph_oe[i] : 1'b1;
			assign oe1 = route1.claimed[i] ? route1.periph_oe[i] : 1'b1;
			// Push-pull only when digital and not SMBus
			assign pp0 = port0_output_drive[i] & port0_input_mode[i]
				& ~route0.smbus_pin[i]; // R9 R10
			assign pp1 = port1_output_drive[i] & port1_input_mode[i]
				& ~route1.smbus_pin[i]; // R9 R10
			// Pin pulled low by its own driver
			assign low0 = crossbar_enable_bit & oe0 & ~d0;
			assign low1 = crossbar_enable_bit & oe1 & ~d1;

			// Output level
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					port0_out[i] <= 1'b0;
					port1_out[i] <= 1'b0;
				end else begin
					port0_out[i] <= d0; // R6
					port1_out[i] <= d1; // R6
				end
			end

			// Output enable
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					port0_oe[i] <= 1'b0;
					port1_oe[i] <= 1'b0;
				end else begin
					port0_oe[i] <= crossbar_enable_bit & port0_input_mode[i]
						& oe0 & (pp0 | ~d0); // R6 R8 R16
					port1_oe[i] <= crossbar_enable_bit & port1_input_mode[i]
						& oe1 & (pp1 | ~d1); // R6 R8 R16
				end
			end

			// Weak pull-up, off while the pin drives low
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					port0_pullup[i] <= 1'b0;
					port1_pullup[i] <= 1'b0;
				end else begin
					port0_pullup[i] <= ~weak_pullup_disable & ~pp0
						& port0_input_mode[i] & ~low0; // R17 R8
					port1_pullup[i] <= ~weak_pullup_disable & ~pp1
						& port1_input_mode[i] & ~low1; // R17 R8
				end
			end

			// Analog flag
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					port0_analog[i] <= 1'b0;
					port1_analog[i] <= 1'b0;
				end else begin
					port0_analog[i] <= ~port0_input_mode[i]; // R8
					port1_analog[i] <= ~port1_input_mode[i]; // R8
				end
			end
		end
	endgenerate

	// Port 2 single pin and skip outputs
	logic d2, oe2, pp2;
	assign d2 = port2_claimed ? port2_periph_out : port2_latch[port2_bit];
	assign oe2 = port2_claimed ? port2_periph_oe : 1'b1;
	assign pp2 = port2_output_drive & ~port2_smbus_pin; // R10

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port2_out <= 1'b0;
			port2_oe <= 1'b0;
			port2_pullup <= 1'b0;
		end else begin
			port2_out <= d2; // R6 R15
			port2_oe <= crossbar_enable_bit & oe2 & (pp2 | ~d2); // R6 R16
			port2_pullup <= ~weak_pullup_disable & ~pp2
				& ~(crossbar_enable_bit & oe2 & ~d2); // R17
		end
	end

	// Skip bits handed to the crossbar decoder
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			port0_crossbar_skip <= reset_crossbar_skip;
			port1_crossbar_skip <= reset_crossbar_skip;
		end else begin
			port0_crossbar_skip <= skip0_reg; // R11
			port1_crossbar_skip <= skip1_reg; // R11
		end
	end
endmodule
`default_nettype wire

/* File: testbench/general_purpose_port_io_sva.sv */
// Checker for port 0 pin controls and register read responses
`timescale 1ns/1ns
`default_nettype none
module gpio_port_checker
	import gpio_port_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	input wire sfr_request_type sfr_req,
	input wire logic [7:0] sfr_rdata,
	input wire logic sfr_hit,
	input wire logic crossbar_enable_bit,
	input wire logic weak_pullup_disable,
	input wire route_type route0,
	input wire logic [7:0] port0_out,
	input wire logic [7:0] port0_oe,
	input wire logic [7:0] port0_pullup,
	input wire logic [7:0] port0_analog
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);
	a_xbar_off_quiet: assert property (!crossbar_enable_bit |=> !port0_oe)
		else $error("pin driven while crossbar off");
	a_analog_quiet: assert property (!(port0_analog & (port0_oe | port0_pullup)))
		else $error("analog pin has driver or pull-up");
	a_pullup_off: assert property (weak_pullup_disable |=> !port0_pullup)
		else $error("pull-up on while disabled");
	a_low_no_pull: assert property (!(port0_oe & ~port0_out & port0_pullup))
		else $error("pull-up on pin driving low");
	a_smbus_open: assert property (!($past(route0.smbus_pin) & port0_oe & port0_out))
		else $error("bus pin driven high");
	a_hit_pulse: assert property (!sfr_req.read |=> !sfr_hit)
		else $error("hit without read");
	a_port2_read: assert property (sfr_req.read && sfr_req.addr == addr_port2_latch
		|=> sfr_hit && sfr_rdata[7:1] == 7'h00)
		else $error("port 2 upper bits not zero");
	a_unmapped_zero: assert property (sfr_req.read && sfr_req.addr == 8'h81
		|=> !sfr_hit && sfr_rdata == unused_read_value)
		else $error("unmapped read answered");
	cover property (sfr_hit);
	cover property (port0_oe != 8'h00);
	cover property (port0_analog != 8'h00);
endmodule
bind general_purpose_port_io gpio_port_checker gpio_port_checker_inst (.clk, .rst_n,
	.sfr_req, .sfr_rdata, .sfr_hit, .crossbar_enable_bit, .weak_pullup_disable,
	.route0, .port0_out, .port0_oe, .port0_pullup, .port0_analog);
`default_nettype wire

/* File: testbench/pin_model.sv */
// Board model of eight pins with outside drivers
`timescale 1ns/1ns
`default_nettype none
module pin_model (
	input wire logic clk,
	input wire logic [7:0] oe,
	input wire logic [7:0] out,
	input wire logic [7:0] weak_pull,
	input wire logic [7:0] ext_en,
	input wire logic [7:0] ext_val,
	output logic [7:0] pin
);
	logic [7:0] drift = 8'h5a;
	// Undriven, unpulled pins wander
	always @(posedge clk) drift <= ~drift;
	assign pin = (oe & out) | (~oe & ext_en & ext_val)
		| (~oe & ~ext_en & (weak_pull | drift));
endmodule
`default_nettype wire

/* File: testbench/general_purpose_port_io_bench.sv */
// Self-checking bench for the port block
`timescale 1ns/1ns
`default_nettype none
module general_purpose_port_io_bench;
	import gpio_port_pkg::*;
	logic clk = 0, rst_n = 0, crossbar_enable_bit = 0, weak_pullup_disable = 0;
	sfr_request_type sfr_req = '0;
	route_type route0 = '0, route1 = '0;
	logic port2_claimed = 0, port2_periph_out = 0, port2_periph_oe = 0;
	logic port2_smbus_pin = 0, port2_output_drive = 0, port2_in = 0;
	logic sfr_hit, port2_out, port2_oe, port2_pullup;
	logic [7:0] sfr_rdata, port0_in, port1_in, port0_out, port0_oe, port0_pullup;
	logic [7:0] port0_analog, port1_out, port1_oe, port1_pullup, port1_analog;
	logic [7:0] port0_crossbar_skip, port1_crossbar_skip, v, m, p, b;
	logic [7:0] ext_en = 8'h00, ext_val = 8'h00, cv [6];
	logic [7:0] ca [6] = '{8'ha4, 8'ha5, 8'hd4, 8'hd5, 8'hf1, 8'hf2};
	logic [7:0] cr [6] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'hff, 8'hff};
	int miscompares = 0, cmp_count = 0, cycles = 0, seed = 32'hb56c_f098;
	general_purpose_port_io general_purpose_port_io_inst (.clk, .rst_n, .sfr_req,
		.sfr_rdata, .sfr_hit, .crossbar_enable_bit, .weak_pullup_disable, .route0,
		.route1, .port2_claimed, .port2_periph_out, .port2_periph_oe,
		.port2_smbus_pin, .port2_output_drive, .port0_in, .port1_in, .port2_in,
		.port0_out, .port0_oe, .port0_pullup, .port0_analog, .port1_out, .port1_oe,
		.port1_pullup, .port1_analog, .port2_out, .port2_oe, .port2_pullup,
		.port0_crossbar_skip, .port1_crossbar_skip);
	pin_model pin_model_inst0 (.clk, .oe(port0_oe), .out(port0_out),
		.weak_pull(port0_pullup), .ext_en, .ext_val, .pin(port0_in));
	pin_model pin_model_inst1 (.clk, .oe(port1_oe), .out(port1_out),
		.weak_pull(port1_pullup), .ext_en, .ext_val, .pin(port1_in));
	initial forever #25 clk = ~clk;
	always @(posedge clk) begin
		cycles++;
		if (cycles == 3000) begin
			miscompares++;
			tally_and_finish;
		end
	end
	function logic [7:0] put_bit(logic [7:0] x, logic [2:0] k, logic b);
		x[k] = b;
		return x;
	endfunction
	function automatic logic [7:0] rnd8();
		int r;
		r = $random(seed);
		return r[7:0];
	endfunction
	// Port 2 pin controls: b holds latch, mode, bus, enables and routing
	function logic [7:0] pin2_exp(logic [7:0] b);
		logic d, en, pp;
		d = b[5] ? b[6] : b[0];
		en = b[5] ? b[7] : 1'b1;
		pp = b[1] & ~b[2];
		return {5'h00, d, b[3] & en & (pp | ~d),
			~b[4] & ~pp & ~(b[3] & en & ~d)};
	endfunction
	task chk(string name, logic [7:0] exp, logic [7:0] got);
		cmp_count++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	task acc(logic [7:0] a, logic w, r, rmw, b, logic [2:0] k, logic [7:0] d);
		@(posedge clk) sfr_req <= '{a, w, r, rmw, b, k, d};
		@(posedge clk) sfr_req <= '0;
		#1;
	endtask
	task wr(logic [7:0] a, logic [7:0] d);
		acc(a, 1, 0, 0, 0, 0, d);
	endtask
	task rd(logic [7:0] a, logic rmw, logic [7:0] exp, logic h);
		acc(a, 0, 1, rmw, 0, 0, 0);
		chk("rdata", exp, sfr_rdata);
		chk("hit", {7'h00, h}, {7'h00, sfr_hit});
	endtask
	task settle;
		repeat (4) @(posedge clk);
		#1;
	endtask
	task tally_and_finish;
		if (miscompares == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (2) @(posedge clk);
		rst_n <= 1;
		rd(addr_port0_latch, 1, reset_port_latch, 1);
		rd(addr_port1_latch, 1, reset_port_latch, 1);
		rd(addr_port2_latch, 1, reset_port2_latch, 1);
		rd(8'h81, 0, unused_read_value, 0);
		foreach (ca[j]) begin
			rd(ca[j], 0, cr[j], 1);
			cv[j] = rnd8();
			wr(ca[j], cv[j]);
			rd(ca[j], 0, cv[j], 1);
		end
		chk("skip0", cv[2], port0_crossbar_skip);
		chk("skip1", cv[3], port1_crossbar_skip);
		wr(addr_port1_input_mode, 8'hff);
		crossbar_enable_bit <= 1;
		for (int i = 0; i < 6; i++) begin
			v = i ? rnd8() : 8'h00;
			m = i ? rnd8() : 8'hff;
			wr(addr_port0_output_drive, i[0] ? 8'hff : 8'h00);
			wr(addr_port1_output_drive, i[0] ? 8'h00 : 8'hff);
			wr(addr_port0_input_mode, m);
			wr(addr_port0_crossbar_skip, ~m);
			wr(addr_port0_latch, v);
			wr(addr_port1_latch, ~v);
			settle;
			chk("pin1", ~v, port1_in);
			chk("analog0", ~m, port0_analog);
			chk("pull1", i[0] ? ~v : 8'h00, port1_pullup);
			rd(addr_port0_latch, 0, v & m, 1);
			acc(addr_port1_latch, 1, 0, 0, 1, v[2:0], {7'h00, v[7]});
			rd(addr_port1_latch, 1, put_bit(~v, v[2:0], v[7]), 1);
		end
		p = rnd8();
		route0 <= '{8'hff, p, 8'hff, 8'h0f};
		route1 <= '{8'hff, p, 8'hff, 8'h0f};
		settle;
		rd(addr_port0_latch, 0, p & m, 1);
		crossbar_enable_bit <= 0;
		weak_pullup_disable <= 1;
		ext_en <= 8'hff;
		ext_val <= ~p;
		port2_output_drive <= 1;
		port2_in <= p[0];
		wr(addr_port2_latch, 8'hfe);
		settle;
		rd(addr_port1_latch, 0, ~p, 1);
		rd(addr_port2_latch, 0, {7'h00, p[0]}, 1);
		rd(addr_port2_latch, 1, 8'h00, 1);
		port2_in <= ~p[0];
		rd(addr_port2_latch, 0, {7'h00, p[0]}, 1);
		rd(addr_port2_latch, 0, {7'h00, ~p[0]}, 1);
		for (int k = 0; k < 8; k++) begin
			b = rnd8();
			port2_output_drive <= b[1];
			port2_smbus_pin <= b[2];
			crossbar_enable_bit <= b[3];
			weak_pullup_disable <= b[4];
			port2_claimed <= b[5];
			port2_periph_out <= b[6];
			port2_periph_oe <= b[7];
			wr(addr_port2_latch, b);
			settle;
			chk("pin2", pin2_exp(b),
				{5'h00, port2_out, port2_oe, port2_pullup});
		end
		tally_and_finish;
	end
endmodule
`default_nettype wire
